// File: mosc_bridge_model.sv
// behavioural model of the three external half bridges on the gate outputs
`timescale 1ns/1ps
module mosc_bridge_model (
  // clock
  input wire logic i_sys_clk,
  // gate drives from the block
  input wire mosc_pkg::mosc_gate_t i_gate,
  // phase node levels and shoot-through count
  output logic [2:0] o_node,
  output int o_shoot
);
  import mosc_pkg::*;

  initial begin
    o_node = 3'h0;
    o_shoot = 0;
  end

  // node follows conducting side
  // a floating node toggles so a stale level is never mistaken for drive
  always @(posedge i_sys_clk) begin
    for (int p = 0; p < 3; p++) begin
      if (i_gate.hi[p] && !i_gate.lo[p]) o_node[p] <= 1'b1;
      else if (i_gate.lo[p] && !i_gate.hi[p]) o_node[p] <= 1'b0;
      else o_node[p] <= ~o_node[p];
    end
  end

  always @(posedge i_sys_clk) begin
    if (|(i_gate.hi & i_gate.lo)) o_shoot <= o_shoot + 1;
  end
endmodule : mosc_bridge_model

// File: mosc_consts.svh
// constants of the motor output stage control block
`ifndef MOSC_CONSTS_SVH
`define MOSC_CONSTS_SVH

// register byte offsets
`define MOSC_OFS_CTRL 4'h0
`define MOSC_OFS_DUTY 4'h4
`define MOSC_OFS_STATUS 4'h8

// control register field positions
`define MOSC_CTRL_DIR_INV 0
`define MOSC_CTRL_BRAKE_POLARITY_INVERT 1
`define MOSC_CTRL_GAP_DIS 2
`define MOSC_CTRL_GAP_LSB 3
`define MOSC_CTRL_FREQ_LSB 8
`define MOSC_CTRL_SRC_LSB 12
`define MOSC_CTRL_SINK_LSB 16

// reset values
`define MOSC_CTRL_RESET 32'h0000_0000
`define MOSC_DUTY_RESET 10'h000

// chopping period divisions, clock cycles per period
`define MOSC_DIV_512 10'h200
`define MOSC_DIV_256 10'h100
`define MOSC_DIV_128 10'h080
`define MOSC_DIV_64 10'h040

// dead time lengths in clock cycles
`define MOSC_GAP_CLK0 5'h03
`define MOSC_GAP_CLK1 5'h06
`define MOSC_GAP_CLK2 5'h0C
`define MOSC_GAP_CLK3 5'h12

// speed band edges in Hz electrical, rising and falling
`define MOSC_UP_EDGE0 16'h00C8
`define MOSC_UP_EDGE1 16'h0190
`define MOSC_UP_EDGE2 16'h0258
`define MOSC_UP_EDGE3 16'h0320
`define MOSC_UP_EDGE4 16'h03E8
`define MOSC_DN_EDGE0 16'h0064
`define MOSC_DN_EDGE1 16'h012C
`define MOSC_DN_EDGE2 16'h01F4
`define MOSC_DN_EDGE3 16'h02BC
`define MOSC_DN_EDGE4 16'h0384
`define MOSC_TOP_BAND 3'h5

`endif

// File: mosc_gap_timer.sv
// dead time counter for the motor output stage control block
`timescale 1ns/1ps
module mosc_gap_timer (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  // control
  input wire logic i_start,
  input wire logic [4:0] i_len,
  // status
  output logic o_busy,
  output logic o_done
);
  logic [4:0] cnt_r;
  logic [4:0] cnt_nxt;
  logic done_r;
  logic done_nxt;

  // load on start, count down to zero; done pulses for one cycle as the count reaches zero
  always_comb begin
    cnt_nxt = cnt_r;
    done_nxt = 1'b0;
    if (i_start) begin
      cnt_nxt = i_len;
    end else if (cnt_r != 5'h00) begin
      cnt_nxt = cnt_r - 5'h01;
      done_nxt = (cnt_r == 5'h01);
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      cnt_r <= 5'h00;
      done_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      done_r <= done_nxt;
    end
  end

  assign o_busy = (cnt_r != 5'h00);
  assign o_done = done_r;

  // a started gap always ends exactly when the count runs out
  AST_GAP_ENDS: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (cnt_r == 5'h01 && !i_start) |=> (o_done && !o_busy)) // [RQ10]
    else $error("gap timer did not finish on count one");
endmodule : mosc_gap_timer

// File: mosc_pkg.sv
// types shared by the motor output stage control block
package mosc_pkg;

  // gate drive pair per phase, index 0 = U, 1 = V, 2 = W
  typedef struct packed {
    logic [2:0] hi;
    logic [2:0] lo;
  } mosc_gate_t;

  // drive sequencing states, gray along run -> gap -> brake
  typedef enum logic [1:0] {
    MOSC_RUN = 2'b00,
    MOSC_GAP = 2'b01,
    MOSC_BRAKE = 2'b11
  } mosc_state_t;

  // chopping division codes, 0 = 512 down to 3 = 64
  typedef logic [1:0] mosc_div_t;

endpackage : mosc_pkg

// File: mosc_top.sv
// motor output stage control: direction, brake, chopping, dead time, gate codes
//
// How it works
// [RQ1] direction from pin, swapped by invert bit
// [RQ2] brake pin level, polarity bit selects active
// [RQ3] chop period is clock divided 512..64
// [RQ4] codes 0-3 fixed, 4-7 speed band profile
// [RQ5] band edges rise 200..1000, fall 100..900
// [RQ6] three phases, separate high and low gates
// [RQ7] three-bit gate charging current code output
// [RQ8] three-bit gate discharging current code output
// [RQ9] dead time on brake or reversal, bit disables
// [RQ10] dead time 3, 6, 12 or 18 cycles
// [RQ11] high and low never on together
//
// The register offsets and the Avalon-MM register port were decided locally.
`timescale 1ns/1ps
`include "mosc_consts.svh"
module mosc_top (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  // avalon-mm slave
  input wire logic [3:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // system pins
  input wire logic i_direction_select_pin,
  input wire logic i_brake_pin,
  // commutation side
  input wire logic [15:0] i_elec_speed_hz,
  input wire mosc_pkg::mosc_gate_t i_phase_cmd,
  // gate drive side
  output mosc_pkg::mosc_gate_t o_gate,
  output logic [2:0] o_source_code,
  output logic [2:0] o_sink_code
);
  import mosc_pkg::*;

  logic [31:0] ctrl_r;
  logic [31:0] ctrl_nxt;
  logic [9:0] duty_r;
  logic [9:0] duty_nxt;
  logic ack_r;
  logic ack_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic bus_req;
  logic wr_take;
  logic dir_inv;
  logic brake_polarity_invert;
  logic auto_gap_disable;
  logic [1:0] shoot_through_gap_select;
  logic [2:0] chop_frequency_select;
  logic dir_ccw;
  logic brake_req;
  logic [2:0] band_r;
  logic [2:0] band_nxt;
  mosc_div_t div_r;
  mosc_div_t div_nxt;
  mosc_div_t div_want;
  logic [9:0] cnt_r;
  logic [9:0] cnt_nxt;
  logic period_end;
  logic pwm_on;
  mosc_state_t state_r;
  mosc_state_t state_nxt;
  logic dir_app_r;
  logic dir_app_nxt;
  logic gap_start;
  logic [4:0] gap_len;
  logic gap_busy;
  logic gap_done;
  mosc_gate_t cmd_dir;
  mosc_gate_t gate_r;
  mosc_gate_t gate_nxt;

  // byte-lane merge for register writes
  function automatic logic [31:0] merge_be(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0] be);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction : merge_be

  // cycles per chopping period for a division code
  function automatic logic [9:0] div_len(input mosc_div_t code);
    logic [9:0] len;
    unique case (code)
      2'h0: len = `MOSC_DIV_512;
      2'h1: len = `MOSC_DIV_256;
      2'h2: len = `MOSC_DIV_128;
      2'h3: len = `MOSC_DIV_64;
    endcase
    return len;
  endfunction : div_len

  // rising band edges: leave band b upward above this speed
  function automatic logic [15:0] up_edge(input logic [2:0] b);
    logic [15:0] e;
    e = `MOSC_UP_EDGE4;
    unique case (b)
      3'h0: e = `MOSC_UP_EDGE0;
      3'h1: e = `MOSC_UP_EDGE1;
      3'h2: e = `MOSC_UP_EDGE2;
      3'h3: e = `MOSC_UP_EDGE3;
      default: e = `MOSC_UP_EDGE4;
    endcase
    return e;
  endfunction : up_edge

  // falling band edges: leave band b downward at or below this speed
  function automatic logic [15:0] dn_edge(input logic [2:0] b);
    logic [15:0] e;
    e = `MOSC_DN_EDGE0;
    unique case (b)
      3'h1: e = `MOSC_DN_EDGE0;
      3'h2: e = `MOSC_DN_EDGE1;
      3'h3: e = `MOSC_DN_EDGE2;
      3'h4: e = `MOSC_DN_EDGE3;
      default: e = `MOSC_DN_EDGE4;
    endcase
    return e;
  endfunction : dn_edge

  // frequency profile: fixed codes ignore the band
  function automatic mosc_div_t profile(input logic [2:0] sel, input logic [2:0] b);
    mosc_div_t d;
    d = 2'h0;
    unique case (sel)
      3'h0: d = 2'h0;
      3'h1: d = 2'h1;
      3'h2: d = 2'h2;
      3'h3: d = 2'h3;
      3'h4: d = (b < 3'h2) ? 2'h1 : ((b < 3'h5) ? 2'h2 : 2'h3);
      3'h5: d = (b == 3'h0) ? 2'h0 : ((b == 3'h1) ? 2'h1 : 2'h2);
      3'h6: d = (b < 3'h2) ? 2'h0 : ((b < 3'h4) ? 2'h1 : 2'h2);
      3'h7: d = (b == 3'h0) ? 2'h0 : ((b == 3'h1) ? 2'h1 : ((b < 3'h4) ? 2'h2 : 2'h3));
    endcase
    return d;
  endfunction : profile

  // bus slave: one wait cycle, then answer; readdata is a flop
  assign bus_req = i_avs_read | i_avs_write;
  assign o_avs_waitrequest = bus_req & ~ack_r;
  assign wr_take = i_avs_write & ack_r;

  always_comb begin
    ack_nxt = bus_req & ~ack_r;
    ctrl_nxt = ctrl_r;
    duty_nxt = duty_r;
    rdata_nxt = rdata_r;
    if (wr_take && i_avs_address == `MOSC_OFS_CTRL) begin
      ctrl_nxt = merge_be(ctrl_r, i_avs_writedata, i_avs_byteenable) & 32'h0007_771F;
    end
    if (wr_take && i_avs_address == `MOSC_OFS_DUTY) begin
      duty_nxt = 10'(merge_be({22'h000000, duty_r}, i_avs_writedata, i_avs_byteenable));
    end
    // reads are latched in the wait cycle so they stand at the taking edge
    if (i_avs_read && !ack_r) begin
      unique case (i_avs_address)
        `MOSC_OFS_CTRL: rdata_nxt = ctrl_r;
        `MOSC_OFS_DUTY: rdata_nxt = {22'h000000, duty_r};
        `MOSC_OFS_STATUS: rdata_nxt = {20'h00000, 1'b0, band_r, 2'h0, div_r,
                                       state_r, brake_req, dir_app_r};
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      ack_r <= 1'b0;
      ctrl_r <= `MOSC_CTRL_RESET;
      duty_r <= `MOSC_DUTY_RESET;
      rdata_r <= 32'h0000_0000;
    end else begin
      ack_r <= ack_nxt;
      ctrl_r <= ctrl_nxt;
      duty_r <= duty_nxt;
      rdata_r <= rdata_nxt;
    end
  end
  assign o_avs_readdata = rdata_r;

  // control field decode
  assign dir_inv = ctrl_r[`MOSC_CTRL_DIR_INV];
  assign brake_polarity_invert = ctrl_r[`MOSC_CTRL_BRAKE_POLARITY_INVERT];
  assign auto_gap_disable = ctrl_r[`MOSC_CTRL_GAP_DIS];
  assign shoot_through_gap_select = ctrl_r[`MOSC_CTRL_GAP_LSB +: 2];
  assign chop_frequency_select = ctrl_r[`MOSC_CTRL_FREQ_LSB +: 3];
  // [RQ7] charging current code
  assign o_source_code = ctrl_r[`MOSC_CTRL_SRC_LSB +: 3];
  // [RQ8] discharging current code
  assign o_sink_code = ctrl_r[`MOSC_CTRL_SINK_LSB +: 3];

  // [RQ1] direction resolve
  assign dir_ccw = i_direction_select_pin ^ dir_inv;
  // [RQ2] brake polarity
  assign brake_req = i_brake_pin ^ brake_polarity_invert;

  // [RQ5] band hysteresis, one band step per cycle at most
  always_comb begin
    band_nxt = band_r;
    if (band_r < `MOSC_TOP_BAND && i_elec_speed_hz > up_edge(band_r)) begin
      band_nxt = band_r + 3'h1;
    end else if (band_r != 3'h0 && i_elec_speed_hz <= dn_edge(band_r)) begin
      band_nxt = band_r - 3'h1;
    end
  end

  // [RQ4] profile lookup
  assign div_want = profile(chop_frequency_select, band_r);

  // [RQ3] carrier counter; the division only changes at a period end
  // so a band step never cuts a chopping pulse short
  assign period_end = (cnt_r == div_len(div_r) - 10'h001);
  always_comb begin
    cnt_nxt = period_end ? 10'h000 : cnt_r + 10'h001;
    div_nxt = period_end ? div_want : div_r;
  end
  // duty is in 1/512 steps, scaled to the current period length
  assign pwm_on = ({cnt_r[8:0], 1'b0} << div_r) < {duty_r[8:0], 1'b0} || duty_r[9];

  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      band_r <= 3'h0;
      cnt_r <= 10'h000;
      div_r <= 2'h0;
    end else begin
      band_r <= band_nxt;
      cnt_r <= cnt_nxt;
      div_r <= div_nxt;
    end
  end

  // [RQ10] dead time length
  always_comb begin
    unique case (shoot_through_gap_select)
      2'h0: gap_len = `MOSC_GAP_CLK0;
      2'h1: gap_len = `MOSC_GAP_CLK1;
      2'h2: gap_len = `MOSC_GAP_CLK2;
      2'h3: gap_len = `MOSC_GAP_CLK3;
    endcase
  end

  mosc_gap_timer i_mosc_gap_timer (
    .i_sys_clk(i_sys_clk),
    .i_resetn(i_resetn),
    .i_start(gap_start),
    .i_len(gap_len),
    .o_busy(gap_busy),
    .o_done(gap_done)
  );

  // [RQ9] sequencing: brake entry and reversal pass through a gap
  always_comb begin
    state_nxt = state_r;
    dir_app_nxt = dir_app_r;
    gap_start = 1'b0;
    unique case (state_r)
      MOSC_RUN: begin
        if (brake_req || dir_ccw != dir_app_r) begin
          if (auto_gap_disable) begin
            state_nxt = brake_req ? MOSC_BRAKE : MOSC_RUN;
            dir_app_nxt = dir_ccw;
          end else begin
            state_nxt = MOSC_GAP;
            gap_start = 1'b1;
          end
        end
      end
      MOSC_GAP: begin
        if (gap_done || !gap_busy) begin
          state_nxt = brake_req ? MOSC_BRAKE : MOSC_RUN;
          dir_app_nxt = dir_ccw;
        end
      end
      MOSC_BRAKE: begin
        if (!brake_req) begin
          state_nxt = MOSC_RUN;
          dir_app_nxt = dir_ccw;
        end
      end
      default: state_nxt = MOSC_RUN;
    endcase
  end

  // reverse rotation swaps the V and W commands
  assign cmd_dir.hi = dir_app_r ? {i_phase_cmd.hi[1], i_phase_cmd.hi[2], i_phase_cmd.hi[0]}
                                : i_phase_cmd.hi;
  assign cmd_dir.lo = dir_app_r ? {i_phase_cmd.lo[1], i_phase_cmd.lo[2], i_phase_cmd.lo[0]}
                                : i_phase_cmd.lo;

  // [RQ6] gate outputs per phase
  always_comb begin
    gate_nxt.hi = 3'h0;
    gate_nxt.lo = 3'h0;
    unique case (state_r)
      MOSC_RUN: begin
        // [RQ11] a phase commanded both ways drives neither gate
        gate_nxt.hi = cmd_dir.hi & ~cmd_dir.lo & {3{pwm_on}};
        gate_nxt.lo = cmd_dir.lo & ~cmd_dir.hi;
      end
      MOSC_BRAKE: begin
        gate_nxt.lo = 3'h7;
      end
      default: begin
        gate_nxt.hi = 3'h0;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      state_r <= MOSC_RUN;
      dir_app_r <= 1'b0;
      gate_r <= '0;
    end else begin
      state_r <= state_nxt;
      dir_app_r <= dir_app_nxt;
      gate_r <= gate_nxt;
    end
  end
  assign o_gate = gate_r;

  // checks
  AST_NO_OVERLAP: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (o_gate.hi & o_gate.lo) == 3'h0) // [RQ11]
    else $error("high and low gate of one phase both on");
  AST_BRAKE_LOWS: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    state_r == MOSC_BRAKE |=> o_gate.lo == 3'h7 && o_gate.hi == 3'h0) // [RQ2]
    else $error("brake state does not short the low sides");
  AST_GAP_DARK: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    state_r == MOSC_GAP |=> o_gate == '0) // [RQ9]
    else $error("gates driven during dead time");
  AST_GAP_ON_BRAKE: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (state_r == MOSC_RUN && brake_req && !auto_gap_disable) |=> state_r == MOSC_GAP) // [RQ9]
    else $error("brake entry skipped the dead time");
  AST_GAP_LEN: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (gap_start && shoot_through_gap_select == 2'h0) |=> gap_busy [*3] ##1 !gap_busy) // [RQ10]
    else $error("shortest dead time is not three cycles");
  AST_DIR_MAP: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (state_r == MOSC_RUN && auto_gap_disable) |=> dir_app_r == $past(dir_ccw)) // [RQ1]
    else $error("applied direction does not follow pin and invert bit");
  AST_FIXED_DIV: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (period_end && chop_frequency_select == 3'h3) |=> div_r == 2'h3) // [RQ4]
    else $error("fixed code did not select division by 64");
  AST_PERIOD: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    cnt_r <= div_len(div_r) - 10'h001) // [RQ3]
    else $error("carrier counter beyond its period");
  AST_BAND_STEP: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    (band_r == 3'h0 && i_elec_speed_hz > `MOSC_UP_EDGE0) |=> band_r == 3'h1) // [RQ5]
    else $error("band did not rise past the first edge");
  AST_BUS_ANSWER: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    ($rose(bus_req) && o_avs_waitrequest) |=> !o_avs_waitrequest)
    else $error("bus answer later than one wait cycle");

  COV_BRAKE: cover property (@(posedge i_sys_clk) disable iff (!i_resetn)
    state_r == MOSC_GAP ##1 state_r == MOSC_BRAKE);
  COV_REVERSE: cover property (@(posedge i_sys_clk) disable iff (!i_resetn)
    state_r == MOSC_GAP ##1 (state_r == MOSC_RUN && dir_app_r));
  COV_TOP_BAND: cover property (@(posedge i_sys_clk) disable iff (!i_resetn)
    band_r == `MOSC_TOP_BAND && div_r == 2'h3);
endmodule : mosc_top

// File: motor_output_stage_control_test.sv
// self-checking testbench of the motor output stage control block
`timescale 1ns/1ps
module motor_output_stage_control_test;
  import mosc_pkg::*;

  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [3:0] addr = 4'h0;
  logic rd_en = 1'b0;
  logic wr_en = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic waitreq;
  logic dir_pin = 1'b0;
  logic brk_pin = 1'b0;
  logic [15:0] speed = 16'h0;
  mosc_gate_t cmd = '0;
  mosc_gate_t gate;
  logic [2:0] src;
  logic [2:0] snk;
  logic [2:0] node;
  int shoot;
  int miscompares = 0;
  int checks = 0;
  logic [31:0] q;
  int zeros;
  int gap_len[4] = '{3, 6, 12, 18};
  int spd[6] = '{0, 1500, 950, 850, 0, 950};
  int band[6] = '{0, 5, 5, 4, 0, 4};
  // division code per profile and band, 0 = 512 .. 3 = 64
  logic [1:0] prof[4][6] = '{'{1, 1, 2, 2, 2, 3}, '{0, 1, 2, 2, 2, 2},
                             '{0, 0, 1, 1, 2, 2}, '{0, 1, 2, 2, 3, 3}};

  always #25 clk = ~clk;

  mosc_top i_mosc_top (
    .i_sys_clk(clk), .i_resetn(rstn), .i_avs_address(addr), .i_avs_read(rd_en),
    .i_avs_write(wr_en), .i_avs_writedata(wdata), .i_avs_byteenable(4'hF),
    .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq), .i_direction_select_pin(dir_pin),
    .i_brake_pin(brk_pin), .i_elec_speed_hz(speed), .i_phase_cmd(cmd), .o_gate(gate),
    .o_source_code(src), .o_sink_code(snk)
  );

  mosc_bridge_model i_mosc_bridge_model (
    .i_sys_clk(clk), .i_gate(gate), .o_node(node), .o_shoot(shoot)
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one avalon transfer; request held until waitrequest is seen low
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    int n;
    n = 0;
    addr <= a;
    wdata <= d;
    wr_en <= w;
    rd_en <= !w;
    do begin
      @(posedge clk);
      n++;
    end while (waitreq !== 1'b0 && n < 50);
    if (n >= 50) chk(32'h1, 32'h0);
    r = rdata;
    wr_en <= 1'b0;
    rd_en <= 1'b0;
    @(posedge clk);
  endtask : bus

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask : wr

  // read status until the masked field matches, then compare it
  task automatic poll(input logic [31:0] m, input logic [31:0] e);
    logic [31:0] r;
    int n;
    n = 0;
    do begin
      bus(1'b0, 4'h8, 32'h0, r);
      n++;
    end while ((r & m) !== e && n < 400);
    chk(r & m, e);
  endtask : poll

  task automatic summarize();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : summarize

  // watchdog sized well above the longest expected run
  initial begin
    #1500000;
    miscompares++;
    summarize();
  end

  initial begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    bus(1'b0, 4'h0, 32'h0, q);
    chk(q, 32'h0);
    chk({src, snk}, 6'h00);
    // unmapped place reads zero and ignores writes
    wr(4'hC, 32'hFFFF_FFFF);
    bus(1'b0, 4'hC, 32'h0, q);
    chk(q, 32'h0);
    bus(1'b0, 4'h0, 32'h0, q);
    chk(q, 32'h0);
    for (int c = 0; c < 8; c++) begin
      wr(4'h0, (c << 12) | ((7 - c) << 16));
      chk({src, snk}, {c[2:0], 3'(7 - c)});
    end
    for (int i = 0; i < 4; i++) begin
      wr(4'h0, i >> 1);
      dir_pin <= i[0];
      poll(32'h1, i[0] ^ i[1]);
    end
    for (int i = 0; i < 4; i++) begin
      wr(4'h0, (i >> 1) << 1);
      brk_pin <= i[0];
      poll(32'h2, (i[0] ^ i[1]) << 1);
      brk_pin <= i[1];
      poll(32'hE, 32'h0);
    end
    // run drive and reversal swapping the v and w commands
    dir_pin <= 1'b0;
    wr(4'h0, 32'h0);
    // brake pin back to the inactive level of the now active-high polarity
    brk_pin <= 1'b0;
    cmd <= '{hi: 3'b001, lo: 3'b010};
    poll(32'hD, 32'h0);
    // zero duty keeps the high side off; full duty lets it through
    chk(gate, 6'b000_010);
    wr(4'h4, 32'hFFFF_FE00);
    bus(1'b0, 4'h4, 32'h0, q);
    chk(q, 32'h0000_0200);
    chk(gate, 6'b001_010);
    chk(node[1:0], 2'b01);
    // a phase commanded both ways drives neither gate
    cmd <= '{hi: 3'b011, lo: 3'b010};
    repeat (2) @(posedge clk);
    chk(gate, 6'b001_000);
    cmd <= '{hi: 3'b001, lo: 3'b010};
    dir_pin <= 1'b1;
    poll(32'hD, 32'h1);
    chk(gate, 6'b001_100);
    chk({node[2], node[0]}, 2'b01);
    dir_pin <= 1'b0;
    poll(32'hD, 32'h0);
    for (int g = 0; g < 5; g++) begin
      wr(4'h0, (g == 4) ? 32'h4 : g << 3);
      poll(32'hC, 32'h0);
      repeat (3) @(posedge clk);
      brk_pin <= 1'b1;
      zeros = 0;
      for (int k = 0; k < 60 && gate.lo !== 3'h7; k++) begin
        @(posedge clk);
        if (gate === 6'h00) zeros++;
      end
      if (g < 4) chk(zeros >= gap_len[g] && zeros <= gap_len[g] + 2, 1);
      else chk(zeros <= 1, 1);
      chk(gate, 6'b000_111);
      brk_pin <= 1'b0;
      poll(32'hC, 32'h0);
    end
    for (int f = 0; f < 4; f++) begin
      wr(4'h0, f << 8);
      poll(32'h30, f << 4);
    end
    for (int f = 4; f < 8; f++) begin
      wr(4'h0, f << 8);
      for (int k = 0; k < 6; k++) begin
        speed <= spd[k][15:0];
        poll(32'h730, (band[k] << 8) | (prof[f - 4][band[k]] << 4));
      end
    end
    chk(shoot, 0);
    summarize();
  end
endmodule : motor_output_stage_control_test
